// ==== src/pot_cmd_pkg.sv ====
/*
  Constants, command codes and states of the dual wiper serial command unit.
  Assumes a 40 MHz system clock and a serial master that keeps whole frames.
*/
// Function
// R01 - frames are 24 bits, shifted in most significant bit first
// R02 - frame splits into 4-bit command, 4-bit address, 16-bit data
// R03 - wiper register sets wiper position directly; zero means terminal B; unlimited rewrites
// R04 - nonvolatile store lasts 15 ms; incoming frames take no effect meanwhile
// R05 - completion output pulses low when a store finishes
// R06 - nonvolatile addresses 2 to 14 hold thirteen 16-bit user words
// R07 - host keeps user data out of nonvolatile address 15
// R08 - codes 0 nop, 1 restore one, 2 store wiper, 3 store data, 8 reload both
// R09 - codes 4/5 halve, 6/7 decrement, 12/13 double, 14/15 increment
// R10 - code 9 reads nonvolatile word, 10 reads wiper, 11 writes wiper
// R11 - write-wiper frame 0xB00100 sets first wiper to 0x100
// R12 - serial output echoes the previous frame during the next transfer
// R13 - power-on loads wipers from nonvolatile words; factory value is midscale
// R14 - preset low sets midscale; preset rising reloads both channels
// R15 - write protect low blocks wiper changes except restores and preset
// R16 - open-drain serial output released whenever chip select is high
// R17 - address bit 0 picks channel; data 9:0 wiper, 15:0 word
// R18 - transfers must hold whole multiples of 24 bits
// R19 - chip select rise clears bit counter unless count is multiple of four
// R20 - chip select pulse without clocks repeats the previous command
// R21 - slave modes: idle-high clock phase 1 or idle-low phase 0
// R22 - host writes wiper, stores it, then waits 15 ms
// R23 - commands execute only when chip select returns high
// R24 - completion pulse ends commands 2, 3, 8, 9, 10 and preset
// R25 - halving and decrement stop at zero
// R26 - doubling and increment saturate at full scale
package pot_cmd_pkg;
    localparam int           FRAME_BITS    = 24;
    localparam logic [4:0]   CNT_LAST      = 5'h17;
    localparam int           CMD_MSB       = 23;
    localparam int           CMD_LSB       = 20;
    localparam int           ADDR_MSB      = 19;
    localparam int           ADDR_LSB      = 16;
    localparam int           DATA_MSB      = 15;
    localparam int           WIPER_BITS    = 10;
    localparam int           NV_WORDS      = 16;
    localparam logic [9:0]   WIPER_MID     = 10'h200;
    localparam logic [9:0]   WIPER_MAX     = 10'h3FF;
    localparam logic [15:0]  NV_WIPER_RST  = 16'h0200;
    localparam logic [15:0]  NV_USER_RST   = 16'h0000;
    localparam logic [3:0]   NV_FACTORY    = 4'hF;
    localparam logic [3:0]   CMD_NOP       = 4'h0;
    localparam logic [3:0]   CMD_RESTORE   = 4'h1;
    localparam logic [3:0]   CMD_STORE_W   = 4'h2;
    localparam logic [3:0]   CMD_STORE_D   = 4'h3;
    localparam logic [3:0]   CMD_HALVE     = 4'h4;
    localparam logic [3:0]   CMD_DEC       = 4'h6;
    localparam logic [3:0]   CMD_RELOAD    = 4'h8;
    localparam logic [3:0]   CMD_READ_NV   = 4'h9;
    localparam logic [3:0]   CMD_READ_W    = 4'hA;
    localparam logic [3:0]   CMD_WRITE_W   = 4'hB;
    localparam logic [3:0]   CMD_DOUBLE    = 4'hC;
    localparam logic [3:0]   CMD_INC       = 4'hE;
    localparam int           CLK_MHZ       = 40;
    localparam int           STORE_TIME_US = 15000;
    localparam int           STORE_CYC     = STORE_TIME_US * CLK_MHZ;
    localparam int           RDY_PULSE_NS  = 100;
    localparam int           RDY_CYC       = (RDY_PULSE_NS * CLK_MHZ + 999) / 1000;

    typedef enum logic [2:0] {
        ST_BOOT  = 3'b001,
        ST_IDLE  = 3'b010,
        ST_STORE = 3'b100
    } state_t;
endpackage : pot_cmd_pkg

// ==== src/dual_wiper_serial_command_unit.sv ====
/*
  Serial command unit for two 10-bit wipers and a 16-word nonvolatile store.
  Assumes the serial clock stands still while chip select is high, and that
  chip select stays high for at least eight system clocks between transfers.
*/
`timescale 1ns/1ps
module dual_wiper_serial_command_unit #(
    parameter int unsigned STORE_CYCLES = pot_cmd_pkg::STORE_CYC
) (
    // system
    input  wire logic                              I_SYS_CLK,
    input  wire logic                              I_RESETN,
    // serial link
    input  wire logic                              I_SCLK,
    input  wire logic                              I_CS_N,
    input  wire logic                              I_SDI,
    output logic                                   O_SDO_O,
    output logic                                   O_SDO_OE_N,
    // control pins
    input  wire logic                              I_WP_N,
    input  wire logic                              I_PRESET_N,
    output logic                                   O_RDY_O,
    output logic                                   O_RDY_OE_N,
    // wiper positions and status
    output logic [pot_cmd_pkg::WIPER_BITS-1:0]     O_WIPER1,
    output logic [pot_cmd_pkg::WIPER_BITS-1:0]     O_WIPER2,
    output logic                                   O_BUSY
);
    import pot_cmd_pkg::*;

    localparam int TMR_W = $clog2(STORE_CYCLES + 1);

    // link domain
    logic [FRAME_BITS-1:0] sreg_r;
    logic [FRAME_BITS-1:0] out_r;
    logic [FRAME_BITS-1:0] out_nxt;
    logic [4:0]            cnt_r;
    logic                  tog_r;
    logic                  sdo_bit;
    // system domain
    logic [2:0]            cs_sync_r;
    logic [2:0]            pr_sync_r;
    logic [1:0]            wp_sync_r;
    logic                  tog_seen_r;
    logic                  cnt_clr_r;
    logic [FRAME_BITS-1:0] prev_r;
    logic [FRAME_BITS-1:0] resp_r;
    logic [FRAME_BITS-1:0] resp_nxt;
    logic [WIPER_BITS-1:0] wiper1_r;
    logic [WIPER_BITS-1:0] wiper2_r;
    logic [WIPER_BITS-1:0] w1_nxt;
    logic [WIPER_BITS-1:0] w2_nxt;
    logic [15:0]           nv_r [NV_WORDS];
    logic [3:0]            st_addr_r;
    logic [15:0]           st_data_r;
    logic [TMR_W-1:0]      tmr_r;
    logic [3:0]            rdy_cnt_r;
    state_t                state_r;
    state_t                state_nxt;

    wire link_cnt_rst_n = I_RESETN & ~cnt_clr_r;
    wire cnt_wrap       = (cnt_r == CNT_LAST);

    // R12 echo word loaded at frame start
    assign out_nxt = (cnt_r == 5'h00) ? {resp_r[FRAME_BITS-2:0], 1'b0}
                                      : {out_r[FRAME_BITS-2:0], 1'b0};
    assign sdo_bit = (cnt_r == 5'h00) ? resp_r[FRAME_BITS-1] : out_r[FRAME_BITS-1];

    // R01 R21 sample on rising edge
    always_ff @(posedge I_SCLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            sreg_r <= '0;
            out_r  <= '0;
            tog_r  <= 1'b0;
        end else if (!I_CS_N) begin
            sreg_r <= {sreg_r[FRAME_BITS-2:0], I_SDI};
            out_r  <= out_nxt;
            tog_r  <= ~tog_seen_r;
        end
    end

    // R18 frame bit counter
    always_ff @(posedge I_SCLK or negedge link_cnt_rst_n) begin
        if (!link_cnt_rst_n) begin
            cnt_r <= 5'h00;
        end else if (!I_CS_N) begin
            cnt_r <= cnt_wrap ? 5'h00 : cnt_r + 5'h01;
        end
    end

    // R16 released while deselected
    assign O_SDO_O    = 1'b0;
    assign O_SDO_OE_N = I_CS_N | sdo_bit;

    // pin synchronisers
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            cs_sync_r <= 3'h7;
            pr_sync_r <= 3'h7;
            wp_sync_r <= 2'h3;
        end else begin
            cs_sync_r <= {cs_sync_r[1:0], I_CS_N};
            pr_sync_r <= {pr_sync_r[1:0], I_PRESET_N};
            wp_sync_r <= {wp_sync_r[0], I_WP_N};
        end
    end

    wire cs_rise  = cs_sync_r[1] & ~cs_sync_r[2];
    wire pr_fall  = ~pr_sync_r[1] & pr_sync_r[2];
    wire pr_rise  = pr_sync_r[1] & ~pr_sync_r[2];
    wire wp_on    = ~wp_sync_r[1];
    wire active   = (tog_r != tog_seen_r);
    wire idle     = (state_r == ST_IDLE);
    // R23 execute on chip select rise
    wire frame_ok = cs_rise & active & (cnt_r == 5'h00);
    // R20 empty pulse repeats
    wire repeat_c = cs_rise & ~active;
    // R19 misaligned count
    wire misalign = cs_rise & (cnt_r[1:0] != 2'h0);
    wire go       = idle & (frame_ok | repeat_c);

    // R02 R17 field decode
    wire [FRAME_BITS-1:0] frm  = frame_ok ? sreg_r : prev_r;
    wire [3:0]            cmd  = frm[CMD_MSB:CMD_LSB];
    wire [3:0]            addr = frm[ADDR_MSB:ADDR_LSB];
    wire [15:0]           data = frm[DATA_MSB:0];
    wire                  ch   = addr[0];
    wire [WIPER_BITS-1:0] sel_w  = ch ? wiper2_r : wiper1_r;
    wire                  is_adj = cmd[2];
    wire                  adj_all = is_adj & cmd[0];
    wire is_store = (cmd == CMD_STORE_W) | ((cmd == CMD_STORE_D) & (addr != NV_FACTORY));
    wire start_st = go & is_store & ~wp_on;
    wire store_end = (state_r == ST_STORE) & (tmr_r == '0);
    wire rdy_cmd  = go & ((cmd == CMD_RELOAD) | (cmd == CMD_READ_NV) | (cmd == CMD_READ_W));
    wire [15:0] st_word = (cmd == CMD_STORE_W) ? {6'h00, sel_w} : data;
    wire [3:0]  st_addr = (cmd == CMD_STORE_W) ? {3'h0, ch} : addr;

    // R09 R25 R26 step and 6 dB moves
    function automatic logic [WIPER_BITS-1:0] adjust(input logic [3:0] c,
                                                     input logic [WIPER_BITS-1:0] w);
        logic [WIPER_BITS-1:0] r;
        r = w;
        case ({c[3], c[1]})
            2'b00:   r = w >> 1;
            2'b01:   r = (w == '0) ? w : w - 10'h001;
            2'b10:   r = w[WIPER_BITS-1] ? WIPER_MAX : {w[WIPER_BITS-2:0], 1'b0};
            2'b11:   r = (w == WIPER_MAX) ? w : w + 10'h001;
            default: r = w;
        endcase
        return r;
    endfunction : adjust

    // wiper next value
    always_comb begin
        w1_nxt = wiper1_r;
        w2_nxt = wiper2_r;
        if (state_r == ST_BOOT) begin
            // R13 power-on load
            w1_nxt = nv_r[0][WIPER_BITS-1:0];
            w2_nxt = nv_r[1][WIPER_BITS-1:0];
        end else if (pr_fall) begin
            // R14 midscale on preset
            w1_nxt = WIPER_MID;
            w2_nxt = WIPER_MID;
        end else if (pr_rise) begin
            w1_nxt = nv_r[0][WIPER_BITS-1:0];
            w2_nxt = nv_r[1][WIPER_BITS-1:0];
        end else if (go) begin
            // R08 R10 R15 command effects
            if (cmd == CMD_RESTORE) begin
                if (ch) begin
                    w2_nxt = nv_r[1][WIPER_BITS-1:0];
                end else begin
                    w1_nxt = nv_r[0][WIPER_BITS-1:0];
                end
            end else if (cmd == CMD_RELOAD) begin
                w1_nxt = nv_r[0][WIPER_BITS-1:0];
                w2_nxt = nv_r[1][WIPER_BITS-1:0];
            end else if ((cmd == CMD_WRITE_W) && !wp_on) begin
                // R03 R11 direct wiper write
                if (ch) begin
                    w2_nxt = data[WIPER_BITS-1:0];
                end else begin
                    w1_nxt = data[WIPER_BITS-1:0];
                end
            end else if (is_adj && !wp_on) begin
                if (adj_all || !ch) begin
                    w1_nxt = adjust(cmd, wiper1_r);
                end
                if (adj_all || ch) begin
                    w2_nxt = adjust(cmd, wiper2_r);
                end
            end
        end
    end

    // R10 R12 readback or echo word
    always_comb begin
        resp_nxt = frm;
        if (cmd == CMD_READ_NV) begin
            resp_nxt = {cmd, addr, nv_r[addr]};
        end else if (cmd == CMD_READ_W) begin
            resp_nxt = {cmd, addr, 6'h00, sel_w};
        end
    end

    // state sequence
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT:  state_nxt = ST_IDLE;
            ST_IDLE:  state_nxt = start_st ? ST_STORE : ST_IDLE;
            ST_STORE: state_nxt = store_end ? ST_IDLE : ST_STORE;
            default:  state_nxt = ST_BOOT;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_r    <= ST_BOOT;
            wiper1_r   <= WIPER_MID;
            wiper2_r   <= WIPER_MID;
            tog_seen_r <= 1'b0;
            cnt_clr_r  <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            wiper1_r   <= w1_nxt;
            wiper2_r   <= w2_nxt;
            tog_seen_r <= cs_rise ? tog_r : tog_seen_r;
            cnt_clr_r  <= misalign;
        end
    end

    // R04 frames ignored while storing
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            prev_r <= '0;
            resp_r <= '0;
        end else if (go) begin
            prev_r <= frm;
            resp_r <= resp_nxt;
        end
    end

    // R04 store timer
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            tmr_r     <= '0;
            st_addr_r <= 4'h0;
            st_data_r <= 16'h0000;
        end else if (start_st) begin
            tmr_r     <= TMR_W'(STORE_CYCLES - 1);
            st_addr_r <= st_addr;
            st_data_r <= st_word;
        end else if (tmr_r != '0) begin
            tmr_r <= tmr_r - 1'b1;
        end
    end

    // R06 nonvolatile words
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            for (int i = 0; i < NV_WORDS; i++) begin
                nv_r[i] <= (i < 2) ? NV_WIPER_RST : NV_USER_RST;
            end
        end else if (store_end) begin
            nv_r[st_addr_r] <= st_data_r;
        end
    end

    // R05 R24 completion pulse
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdy_cnt_r <= 4'h0;
        end else if (store_end || rdy_cmd || (pr_rise && state_r != ST_BOOT)) begin
            rdy_cnt_r <= 4'(RDY_CYC);
        end else if (rdy_cnt_r != 4'h0) begin
            rdy_cnt_r <= rdy_cnt_r - 4'h1;
        end
    end

    assign O_RDY_O    = 1'b0;
    assign O_RDY_OE_N = (rdy_cnt_r == 4'h0);
    assign O_WIPER1   = wiper1_r;
    assign O_WIPER2   = wiper2_r;
    assign O_BUSY     = (state_r != ST_IDLE);

    // checks
    default clocking cb @(posedge I_SYS_CLK);
    endclocking
    default disable iff (!I_RESETN);

    sequence s_rdy_low;
        (O_RDY_OE_N == 1'b0) [*4];
    endsequence

    sequence s_store_go;
        go && is_store && !wp_on;
    endsequence

    property p_rdy_pulse;
        store_end |=> s_rdy_low ##1 O_RDY_OE_N;
    endproperty
    a_rdy_pulse: assert property (p_rdy_pulse) else $error("completion pulse wrong"); // R05

    property p_store_busy;
        s_store_go |=> (state_r == ST_STORE) [*8];
    endproperty
    a_store_busy: assert property (p_store_busy) else $error("store not held busy"); // R04

    property p_store_lock;
        (state_r == ST_STORE) && cs_rise |=> $stable(prev_r) && $stable(resp_r);
    endproperty
    a_store_lock: assert property (p_store_lock) else $error("frame taken during store"); // R04

    property p_write_w1;
        go && (cmd == CMD_WRITE_W) && !ch && !wp_on && !pr_fall && !pr_rise
            |=> wiper1_r == $past(data[WIPER_BITS-1:0]);
    endproperty
    a_write_w1: assert property (p_write_w1) else $error("wiper write lost"); // R11

    property p_halve;
        go && (cmd == CMD_HALVE) && !ch && !wp_on && !pr_fall && !pr_rise
            |=> wiper1_r == ($past(wiper1_r) >> 1);
    endproperty
    a_halve: assert property (p_halve) else $error("halve wrong"); // R25

    property p_inc_sat;
        go && (cmd == CMD_INC) && !ch && !wp_on && !pr_fall && !pr_rise
            && (wiper1_r == WIPER_MAX) |=> wiper1_r == WIPER_MAX;
    endproperty
    a_inc_sat: assert property (p_inc_sat) else $error("increment wrapped"); // R26

    property p_wp_block;
        go && wp_on && (cmd == CMD_WRITE_W) && !pr_fall && !pr_rise
            |=> $stable(wiper1_r) && $stable(wiper2_r);
    endproperty
    a_wp_block: assert property (p_wp_block) else $error("protected wiper changed"); // R15

    property p_preset_mid;
        pr_fall && (state_r != ST_BOOT) |=> wiper1_r == WIPER_MID && wiper2_r == WIPER_MID;
    endproperty
    a_preset_mid: assert property (p_preset_mid) else $error("preset not midscale"); // R14

    property p_boot_load;
        state_r == ST_BOOT |=> wiper1_r == nv_r[0][WIPER_BITS-1:0] && state_r == ST_IDLE;
    endproperty
    a_boot_load: assert property (p_boot_load) else $error("power-on load missing"); // R13

    property p_sdo_release;
        I_CS_N |-> O_SDO_OE_N;
    endproperty
    a_sdo_release: assert property (p_sdo_release) else $error("output driven while idle"); // R16

    property p_misalign;
        misalign |=> cnt_clr_r ##1 !cnt_clr_r;
    endproperty
    a_misalign: assert property (p_misalign) else $error("counter not cleared"); // R19

endmodule : dual_wiper_serial_command_unit

// ==== tb/spi_host_model.sv ====
/*
  Host side of the serial link: a behavioural master shifting n bits per transfer.
  Assumes a pull-up on the open-drain data output and a 160 ns link clock.
*/
`timescale 1ns/1ps
module spi_host_model (
    // serial pins
    output logic            o_sclk,
    output logic            o_cs_n,
    output logic            o_sdi,
    // open-drain return line
    input  wire logic       i_sdo_oe_n
);
    initial begin
        o_sclk = 1'b1;
        o_cs_n = 1'b1;
        o_sdi  = 1'b0;
    end

    task automatic xfer(input int n, input logic [47:0] d, input logic cpol,
                        output logic [47:0] q);
        q      = '0;
        o_sclk = cpol;
        #40;
        o_cs_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            o_sclk = 1'b0;
            o_sdi  = d[i];
            #80;
            q      = {q[46:0], i_sdo_oe_n};
            o_sclk = 1'b1;
            #80;
        end
        o_sclk = cpol;
        #80;
        o_cs_n = 1'b1;
        o_sdi  = ~o_sdi;
        #400;
    endtask : xfer
endmodule : spi_host_model

// ==== tb/dual_wiper_serial_command_unit_bench.sv ====
/*
  Self-checking bench of the dual wiper serial command unit.
  Assumes a shortened store time and the host model on the serial pins.
*/
`timescale 1ns/1ps
module dual_wiper_serial_command_unit_bench;
    import pot_cmd_pkg::*;
    localparam int STORE_N  = 400;
    localparam int LIMIT_NS = 2000000;
    logic                  I_SYS_CLK, I_RESETN, I_SCLK, I_CS_N, I_SDI, I_WP_N, I_PRESET_N;
    logic                  O_SDO_O, O_SDO_OE_N, O_RDY_O, O_RDY_OE_N, O_BUSY;
    logic [WIPER_BITS-1:0] O_WIPER1, O_WIPER2;
    logic [9:0]            mw [2];
    logic [15:0]           mnv [16];
    logic [23:0]           last, echo;
    logic [47:0]           pend;
    logic [31:0]           seed, r;
    logic                  pol, echo_ok, mbusy;
    logic [3:0]            codes [9] = '{4'h0, 4'h4, 4'h5, 4'h6, 4'h7, 4'hC, 4'hD, 4'hE, 4'hF};
    int                    errors, n_compared, mrdy, rdy_seen, pend_n;

    dual_wiper_serial_command_unit #(.STORE_CYCLES(STORE_N)) u_dut (
        .I_SYS_CLK(I_SYS_CLK), .I_RESETN(I_RESETN), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N),
        .I_SDI(I_SDI), .O_SDO_O(O_SDO_O), .O_SDO_OE_N(O_SDO_OE_N), .I_WP_N(I_WP_N),
        .I_PRESET_N(I_PRESET_N), .O_RDY_O(O_RDY_O), .O_RDY_OE_N(O_RDY_OE_N),
        .O_WIPER1(O_WIPER1), .O_WIPER2(O_WIPER2), .O_BUSY(O_BUSY));
    spi_host_model u_host (.o_sclk(I_SCLK), .o_cs_n(I_CS_N), .o_sdi(I_SDI),
                           .i_sdo_oe_n(O_SDO_OE_N));

    always #12.5 I_SYS_CLK = ~I_SYS_CLK;
    always @(negedge O_RDY_OE_N) if (I_RESETN === 1'b1) rdy_seen++;

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [9:0] adj(input logic [3:0] c, input logic [9:0] w);
        case (c[3:1])
            3'b010:  return w >> 1;
            3'b011:  return (w == 10'h000) ? w : w - 10'h001;
            3'b110:  return w[9] ? 10'h3FF : {w[8:0], 1'b0};
            default: return (w == 10'h3FF) ? w : w + 10'h001;
        endcase
    endfunction : adj

    task automatic tick();
        @(posedge I_SYS_CLK);
        #2;
    endtask : tick

    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    task automatic exec(input logic [23:0] f);
        logic [3:0] c;
        logic [3:0] a;
        logic       s;
        c    = f[23:20];
        a    = f[19:16];
        s    = a[0];
        last = f;
        echo = f;
        if (I_WP_N == 1'b0 && !(c inside {4'h0, 4'h1, 4'h8, 4'h9, 4'hA})) return;
        case (c)
            4'h1: mw[s] = mnv[s][9:0];
            4'h2: begin mnv[s] = {6'h0, mw[s]}; mrdy++; mbusy = 1'b1; end
            4'h3: if (a != 4'hF) begin mnv[a] = f[15:0]; mrdy++; mbusy = 1'b1; end
            4'h8: begin mw[0] = mnv[0][9:0]; mw[1] = mnv[1][9:0]; mrdy++; end
            4'h9: begin echo[15:0] = mnv[a]; mrdy++; end
            4'hA: begin echo[15:0] = {6'h0, mw[s]}; mrdy++; end
            4'hB: mw[s] = f[9:0];
            default: for (int k = 0; k < 2; k++) if (c != 4'h0 && (k == s || c[0]))
                mw[k] = adj(c, mw[k]);
        endcase
    endtask : exec

    task automatic check_state();
        check({38'h0, O_WIPER1}, {38'h0, mw[0]});
        check({38'h0, O_WIPER2}, {38'h0, mw[1]});
        check({47'h0, O_BUSY}, {47'h0, mbusy});
        check({47'h0, O_SDO_OE_N}, 48'h1);
        check({46'h0, O_SDO_O, O_RDY_O}, 48'h0);
        if (!mbusy) check(48'(rdy_seen), 48'(mrdy));
    endtask : check_state

    task automatic frame(input int n, input logic [47:0] d);
        logic [47:0] q;
        u_host.xfer(n, d, pol, q);
        if (n == 24 && echo_ok) check(q, {24'h0, echo});
        if (n > 0) echo_ok = 1'b0;
        pend   = (pend << n) | d;
        pend_n = pend_n + n;
        if (mbusy) pend_n = 0;
        else if (n == 0) exec(last);
        else if (pend_n % 24 == 0) begin
            exec(pend[23:0]);
            echo_ok = (n == 24);
            pend_n  = 0;
        end else if (pend_n % 4 != 0) pend_n = 0;
        repeat (4) tick();
        check_state();
    endtask : frame

    task automatic wait_idle();
        for (int k = 0; k < 2 * STORE_N && O_BUSY !== 1'b0; k++) tick();
        mbusy = 1'b0;
        repeat (8) tick();
        check_state();
    endtask : wait_idle

    initial begin
        I_SYS_CLK = 1'b0; I_RESETN = 1'b0; I_WP_N = 1'b1; I_PRESET_N = 1'b1;
        seed = 32'h88EC4602; errors = 0; n_compared = 0; mrdy = 0; rdy_seen = 0;
        pend_n = 0; pend = '0; pol = 1'b1; echo_ok = 1'b0; mbusy = 1'b0;
        last = '0; echo = '0; mw[0] = WIPER_MID; mw[1] = WIPER_MID;
        foreach (mnv[i]) mnv[i] = (i < 2) ? NV_WIPER_RST : NV_USER_RST;
        repeat (5) @(posedge I_SYS_CLK);
        #2;
        I_RESETN = 1'b1;
        repeat (6) tick();
        check_state();
        $display("test power-on done");
        frame(24, 48'hB00100);
        frame(24, 48'h200000);
        frame(24, 48'hB003FF);
        wait_idle();
        frame(24, 48'hB10200);
        frame(24, 48'h210000);
        wait_idle();
        frame(24, 48'hB00000);
        frame(24, 48'h100000);
        frame(24, 48'h800000);
        $display("test store and restore done");
        pol = 1'b0;
        foreach (codes[i]) begin
            r = rnd();
            frame(24, {32'hB0, 6'h0, (i % 3 == 0) ? 10'h000 : (i % 3 == 1) ? 10'h3FF : r[9:0]});
            frame(24, {32'hB1, 6'h0, r[25:16]});
            frame(24, {24'h0, codes[i], 3'h0, r[31] & (i % 3 != 1), 16'h0});
        end
        frame(0, 48'h0);
        $display("test adjust done");
        r = rnd();
        frame(24, {32'h35, r[15:0]});
        wait_idle();
        frame(24, 48'h3F1234);
        frame(24, 48'h950000);
        frame(24, 48'h9F0000);
        frame(24, 48'hA10000);
        frame(24, 48'h000000);
        $display("test readback done");
        I_WP_N = 1'b0;
        repeat (4) tick();
        frame(24, 48'hB00155);
        frame(24, 48'h200000);
        frame(24, 48'hE00000);
        frame(24, 48'h100000);
        frame(24, 48'h800000);
        I_WP_N = 1'b1;
        repeat (4) tick();
        frame(24, 48'hB1007F);
        I_PRESET_N = 1'b0;
        repeat (6) tick();
        mw[0] = WIPER_MID;
        mw[1] = WIPER_MID;
        check_state();
        I_PRESET_N = 1'b1;
        mw[0] = mnv[0][9:0];
        mw[1] = mnv[1][9:0];
        mrdy++;
        repeat (10) tick();
        check_state();
        $display("test protect and preset done");
        frame(23, 48'h7FFFFF);
        frame(24, 48'hB00011);
        frame(12, 48'hB01);
        frame(12, 48'h377);
        frame(48, 48'hB10033E00000);
        $display("test bit count done");
        report_and_stop();
    end

    initial begin
        #(LIMIT_NS);
        errors++;
        report_and_stop();
    end
endmodule : dual_wiper_serial_command_unit_bench
